// ### shared/ppg_pkg.sv
// Package for the printer port and general-purpose pin block.
// Assumes a 32-bit AHB-Lite register bus and a 50 MHz hclk.
package ppg_pkg;

  // Register byte addresses; four of the five printed offsets are not word aligned, so index * 4
  localparam logic [7:0]  PPG_IDX_LEVELS   = 8'h17;
  localparam logic [7:0]  PPG_IDX_CONTROL  = 8'h1a;
  localparam logic [7:0]  PPG_IDX_STATUS   = 8'h1b;
  localparam logic [7:0]  PPG_IDX_DATA     = 8'h1c;
  localparam logic [7:0]  PPG_IDX_RDATA    = 8'h1d;
  localparam logic [9:0]  PPG_ADDR_LEVELS  = {PPG_IDX_LEVELS, 2'b00};
  localparam logic [9:0]  PPG_ADDR_CONTROL = {PPG_IDX_CONTROL, 2'b00};
  localparam logic [9:0]  PPG_ADDR_STATUS  = {PPG_IDX_STATUS, 2'b00};
  localparam logic [9:0]  PPG_ADDR_DATA    = {PPG_IDX_DATA, 2'b00};
  localparam logic [9:0]  PPG_ADDR_RDATA   = {PPG_IDX_RDATA, 2'b00};

  // Levels register fields
  localparam int          PPG_LV_GPO0      = 0;
  localparam int          PPG_LV_GPI0      = 4;
  localparam int          PPG_LV_GPI1      = 5;
  localparam int          PPG_LV_GPI2      = 6;

  // Control register fields
  localparam int          PPG_CT_DRIVE     = 0;
  localparam int          PPG_CT_SELECT    = 1;
  localparam int          PPG_CT_RESTART   = 2;
  localparam int          PPG_CT_AUTOLF    = 3;
  localparam logic [7:0]  PPG_CT_RESET     = 8'h00;

  // Status register fields
  localparam int          PPG_ST_BUSY      = 0;
  localparam int          PPG_ST_TAKEN_N   = 1;
  localparam int          PPG_ST_PAPER     = 2;
  localparam int          PPG_ST_ONLINE    = 3;
  localparam int          PPG_ST_FAULT_N   = 4;
  localparam int          PPG_ST_READY     = 5;
  localparam int          PPG_ST_MODE      = 6;
  localparam int          PPG_ST_FULL      = 7;

  // Latch pulse timing
  localparam int          PPG_CLK_MHZ      = 50;
  localparam int          PPG_SETUP_NS     = 500;
  localparam int          PPG_PULSE_NS     = 1000;
  localparam int          PPG_HOLD_NS      = 500;
  localparam int          PPG_SETUP_CYC    = (PPG_SETUP_NS * PPG_CLK_MHZ + 999) / 1000;
  localparam int          PPG_PULSE_CYC    = (PPG_PULSE_NS * PPG_CLK_MHZ + 999) / 1000;
  localparam int          PPG_HOLD_CYC     = (PPG_HOLD_NS * PPG_CLK_MHZ + 999) / 1000;
  localparam int          PPG_FIFO_DEPTH   = 8;

  typedef enum logic [1:0] {
    PPG_IDLE  = 2'b00,
    PPG_SETUP = 2'b01,
    PPG_PULSE = 2'b10,
    PPG_HOLD  = 2'b11
  } ppg_state_t;

endpackage : ppg_pkg

// ### hw/ppg_fifo.sv
// Byte FIFO between register writes and the printer latch sequencer.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ppg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready    = (count != (AW+1)'(DEPTH));
    out_valid   = (count != '0);
    out_data    = mem[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : ppg_fifo
`default_nettype wire

// ### hw/ppg_top.sv
// Printer port and general-purpose pin logic behind an AHB-Lite register slave.
// Assumes pins arrive asynchronously; the strap is shared with a clock pin and
// is valid while reset is applied.
`timescale 1ns/1ps
`default_nettype none
module ppg_top
  import ppg_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int DEPTH  = PPG_FIFO_DEPTH
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [DATA_W-1:0] printer_data_bus_in,
  output logic      [DATA_W-1:0] printer_data_bus_out,
  output logic                   printer_data_bus_oe,
  input  wire logic              busy,
  input  wire logic              taken_n,
  input  wire logic              paper_out,
  input  wire logic              printer_online,
  input  wire logic              fault_n,
  input  wire logic              printer_port_strap,
  output logic                   printer_select_n,
  output logic                   restart_n,
  output logic                   line_feed_auto_n,
  output logic                   latch_pulse_n,
  output logic                   gp_output
);

  // Synchronisers: stage one is read by stage two only
  localparam int NS = DATA_W + 6;
  // Reset to idle pin levels: no false data-taken edge or strap value after reset
  localparam logic [NS-1:0] SYNC_IDLE = {6'b110010, {DATA_W{1'b0}}};
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  assign pin_raw = {printer_port_strap, fault_n, printer_online, paper_out, taken_n, busy,
                    printer_data_bus_in};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end

  logic [DATA_W-1:0] data_s;
  logic              busy_s;
  logic              taken_n_s;
  logic              paper_s;
  logic              online_s;
  logic              fault_n_s;
  logic              strap_s;
  assign data_s    = sync2[DATA_W-1:0];
  assign busy_s    = sync2[DATA_W];
  assign taken_n_s = sync2[DATA_W+1];
  assign paper_s   = sync2[DATA_W+2];
  assign online_s  = sync2[DATA_W+3];
  assign fault_n_s = sync2[DATA_W+4];
  assign strap_s   = sync2[DATA_W+5];

  // Strap capture: taken once the synchroniser holds the pin, then frozen
  logic       mode_mii;
  logic [1:0] strap_wait;
  logic       next_mode_mii;
  logic [1:0] next_strap_wait;

  always_comb begin
    next_mode_mii   = mode_mii;
    next_strap_wait = strap_wait;
    if (strap_wait != 2'h3) begin
      next_strap_wait = strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        next_mode_mii = strap_s;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_mii   <= 1'b1;
      strap_wait <= 2'h0;
    end else begin
      mode_mii   <= next_mode_mii;
      strap_wait <= next_strap_wait;
    end
  end

  // AHB-Lite slave: zero-wait, always OKAY
  logic       ap_valid;
  logic       ap_write;
  logic [9:0] ap_addr;
  logic       next_ap_valid;
  logic       next_ap_write;
  logic [9:0] next_ap_addr;

  always_comb begin
    next_ap_valid = hsel && hready && htrans[1];
    next_ap_write = hwrite;
    next_ap_addr  = haddr[9:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= '0;
    end else begin
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_addr  <= next_ap_addr;
    end
  end

  logic wr_levels;
  logic wr_control;
  logic wr_data;
  assign wr_levels  = ap_valid && ap_write && (ap_addr == PPG_ADDR_LEVELS);
  assign wr_control = ap_valid && ap_write && (ap_addr == PPG_ADDR_CONTROL);
  assign wr_data    = ap_valid && ap_write && (ap_addr == PPG_ADDR_DATA);

  // Software registers
  logic [7:0] control;
  logic       gp_out_bit;
  logic [7:0] next_control;
  logic       next_gp_out_bit;

  always_comb begin
    next_control = control;
    next_gp_out_bit = gp_out_bit;
    if (wr_control) begin
      next_control = hwdata[7:0];
    end
    if (wr_levels) begin
      next_gp_out_bit = hwdata[PPG_LV_GPO0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control <= PPG_CT_RESET;
      gp_out_bit <= 1'b0;
    end else begin
      control <= next_control;
      gp_out_bit <= next_gp_out_bit;
    end
  end

  // Write-data FIFO; a full FIFO drops the byte, visible as the full status bit
  logic [DATA_W-1:0] fifo_dout;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_pop;

  ppg_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (wr_data),
    .in_ready  (fifo_in_ready),
    .in_data   (hwdata[DATA_W-1:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_dout)
  );

  // Latch sequencer: setup, low pulse, hold
  localparam int CW = 8;
  ppg_state_t        state;
  ppg_state_t        next_state;
  logic [CW-1:0]     cnt;
  logic [CW-1:0]     next_cnt;
  logic [DATA_W-1:0] out_byte;
  logic [DATA_W-1:0] next_out_byte;

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_out_byte = out_byte;
    fifo_pop      = 1'b0;
    case (state)
      PPG_IDLE: begin
        if (fifo_out_valid && !busy_s && !mode_mii) begin
          fifo_pop      = 1'b1;
          next_out_byte = fifo_dout;
          next_cnt      = CW'(PPG_SETUP_CYC - 1);
          next_state    = PPG_SETUP;
        end
      end
      PPG_SETUP: begin
        if (cnt == '0) begin
          next_cnt   = CW'(PPG_PULSE_CYC - 1);
          next_state = PPG_PULSE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      PPG_PULSE: begin
        if (cnt == '0) begin
          next_cnt   = CW'(PPG_HOLD_CYC - 1);
          next_state = PPG_HOLD;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      PPG_HOLD: begin
        if (cnt == '0) begin
          next_state = PPG_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = PPG_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= PPG_IDLE;
      cnt      <= '0;
      out_byte <= '0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      out_byte <= next_out_byte;
    end
  end

  // Data-taken edge sticks until a status read; set beats clear
  logic taken_seen;
  logic taken_prev;
  logic next_taken_seen;
  logic rd_status;
  assign rd_status = next_ap_valid && !hwrite && (haddr[9:0] == PPG_ADDR_STATUS);

  always_comb begin
    next_taken_seen = taken_seen;
    if (rd_status) begin
      next_taken_seen = 1'b0;
    end
    if (taken_prev && !taken_n_s) begin
      next_taken_seen = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      taken_seen <= 1'b0;
      taken_prev <= 1'b1;
    end else begin
      taken_seen <= next_taken_seen;
      taken_prev <= taken_n_s;
    end
  end

  // Read data mux on the address phase; registered so hrdata stands in the data phase
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[9:0])
      PPG_ADDR_LEVELS: begin
        rd_word[PPG_LV_GPI2] = fault_n_s;
        rd_word[PPG_LV_GPI1] = mode_mii & paper_s;
        rd_word[PPG_LV_GPI0] = mode_mii & online_s;
        rd_word[PPG_LV_GPO0] = gp_out_bit;
      end
      PPG_ADDR_CONTROL: begin
        rd_word[7:0] = control;
      end
      PPG_ADDR_STATUS: begin
        rd_word[PPG_ST_BUSY]    = busy_s;
        rd_word[PPG_ST_TAKEN_N] = taken_n_s;
        rd_word[PPG_ST_PAPER]   = paper_s;
        rd_word[PPG_ST_ONLINE]  = online_s;
        rd_word[PPG_ST_FAULT_N] = fault_n_s;
        rd_word[PPG_ST_READY]   = taken_seen;
        rd_word[PPG_ST_MODE]    = mode_mii;
        rd_word[PPG_ST_FULL]    = !fifo_in_ready;
      end
      PPG_ADDR_RDATA: begin
        rd_word[DATA_W-1:0] = data_s;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Registered pin outputs
  logic [DATA_W-1:0] next_bus_out;
  logic              next_bus_oe;
  logic              next_sel_n;
  logic              next_restart_n;
  logic              next_lf_n;
  logic              next_latch_n;
  logic              next_gp_out;
  logic [31:0]       next_hrdata;

  always_comb begin
    next_bus_out   = out_byte;
    next_bus_oe    = control[PPG_CT_DRIVE] && !mode_mii;
    next_sel_n     = !control[PPG_CT_SELECT];
    next_restart_n = !control[PPG_CT_RESTART];
    next_lf_n      = !control[PPG_CT_AUTOLF];
    next_latch_n   = (next_state != PPG_PULSE);
    next_gp_out    = !next_gp_out_bit;
    next_hrdata    = (next_ap_valid && !hwrite) ? rd_word : 32'h0000_0000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      printer_data_bus_out <= '0;
      printer_data_bus_oe  <= 1'b0;
      printer_select_n     <= 1'b1;
      restart_n            <= 1'b1;
      line_feed_auto_n     <= 1'b1;
      latch_pulse_n        <= 1'b1;
      gp_output            <= 1'b1;
      hrdata               <= 32'h0000_0000;
    end else begin
      printer_data_bus_out <= next_bus_out;
      printer_data_bus_oe  <= next_bus_oe;
      printer_select_n     <= next_sel_n;
      restart_n            <= next_restart_n;
      line_feed_auto_n     <= next_lf_n;
      latch_pulse_n        <= next_latch_n;
      gp_output            <= next_gp_out;
      hrdata               <= next_hrdata;
    end
  end
endmodule : ppg_top
`default_nettype wire

// ### tb/ppg_assertions.sv
// Checker for the printer port block, bound to ppg_top.
// Assumes single-word AHB-Lite transfers and the ppg_pkg map.
`timescale 1ns/1ps
`default_nettype none
module ppg_assertions
  import ppg_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        busy,
  input wire logic        fault_n,
  input wire logic [7:0]  printer_data_bus_out,
  input wire logic        printer_data_bus_oe,
  input wire logic        printer_select_n,
  input wire logic        restart_n,
  input wire logic        line_feed_auto_n,
  input wire logic        latch_pulse_n,
  input wire logic        gp_output
);
  logic       ap_w;
  logic [9:0] ap_a;
  logic [7:0] wd;
  logic [7:0] lo_cnt;
  logic [7:0] bh_cnt;
  logic [3:0] fs_cnt;

  // bh_cnt and fs_cnt saturate so long idle stretches cannot wrap into a false pass; lo_cnt wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_w   <= 1'b0;
      ap_a   <= 10'h0;
      wd     <= 8'h0;
      lo_cnt <= 8'h0;
      bh_cnt <= 8'h0;
      fs_cnt <= 4'h0;
    end else begin
      ap_w   <= hsel && hready && htrans[1] && hwrite;
      ap_a   <= haddr[9:0];
      wd     <= ap_w ? hwdata[7:0] : wd;
      lo_cnt <= latch_pulse_n ? 8'h0 : lo_cnt + 8'h1;
      bh_cnt <= !busy ? 8'h0 : ((bh_cnt == 8'hff) ? bh_cnt : bh_cnt + 8'h1);
      fs_cnt <= $changed(fault_n) ? 4'h0 : ((fs_cnt == 4'hf) ? fs_cnt : fs_cnt + 4'h1);
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_wr(logic [9:0] a);
    ap_w && ap_a == a;
  endsequence
  sequence s_rd_lv;
    hsel && hready && htrans[1] && !hwrite && haddr[9:0] == PPG_ADDR_LEVELS && fs_cnt > 4'h4;
  endsequence

  AST_CTL: assert property (
    s_wr(PPG_ADDR_CONTROL) |-> ##[1:2] (printer_select_n == !wd[1] &&
      restart_n == !wd[2] && line_feed_auto_n == !wd[3]))
    else $error("control pins do not follow control write");
  AST_OE_OFF: assert property (
    s_wr(PPG_ADDR_CONTROL) |-> ##[1:2] (wd[0] || !printer_data_bus_oe))
    else $error("data bus driven with direction bit clear");
  AST_GP_OUT: assert property (
    s_wr(PPG_ADDR_LEVELS) |-> ##[1:2] (gp_output == !wd[0]))
    else $error("general output not inverse of written bit");
  AST_LATCH_W: assert property (
    $rose(latch_pulse_n) |-> lo_cnt == PPG_PULSE_CYC)
    else $error("latch pulse width wrong");
  AST_HOLD: assert property (
    !latch_pulse_n |-> $stable(printer_data_bus_out))
    else $error("data changed during latch pulse");
  AST_STALL: assert property (
    $fell(latch_pulse_n) |-> bh_cnt < 8'd30)
    else $error("byte sent while printer busy");
  AST_RST: assert property (
    disable iff (1'b0) !hresetn |-> (latch_pulse_n && gp_output && printer_select_n &&
      restart_n && line_feed_auto_n && !printer_data_bus_oe))
    else $error("outputs not at reset values");
  AST_GPI2: assert property (
    s_rd_lv |=> hrdata[PPG_LV_GPI2] == fault_n)
    else $error("levels bit 6 not general input 2");
  AST_RESP: assert property (
    hreadyout && !hresp)
    else $error("bus response not ready and okay");
endmodule : ppg_assertions
`default_nettype wire

// ### tb/ppg_printer_model.sv
// Behavioural printer: takes a byte when the latch pulse ends.
// Assumes the bench computes the data wire from both drivers.
`timescale 1ns/1ps
`default_nettype none
module ppg_printer_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       latch_pulse_n,
  input  wire logic [7:0] bus,
  input  wire logic [7:0] delay,
  output logic            busy,
  output logic            taken_n
);
  logic [7:0] caps [0:15];
  int         n_cap;
  int         cnt;
  logic       lp_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy    <= 1'b0;
      taken_n <= 1'b1;
      n_cap   <= 0;
      cnt     <= 0;
      lp_q    <= 1'b1;
    end else begin
      lp_q <= latch_pulse_n;
      if (latch_pulse_n && !lp_q) begin
        caps[n_cap[3:0]] <= bus;
        n_cap            <= n_cap + 1;
        busy             <= 1'b1;
        cnt              <= int'(delay) + 8;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
        taken_n <= !(cnt <= 6 && cnt > 1);
        busy    <= (cnt != 1);
      end
    end
  end
endmodule : ppg_printer_model
`default_nettype wire

// ### tb/ppg_top_tb.sv
// Self-checking bench for ppg_top with a printer model on the pins.
// Assumes hreadyout is the bus hready; strap held across reset.
`timescale 1ns/1ps
`default_nettype none
module ppg_top_tb;
  import ppg_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire  [7:0]  bus_out;
  wire         bus_oe;
  wire  [7:0]  bus;
  logic [7:0]  ext_byte;
  logic        paper;
  logic        online;
  logic        fault_n;
  logic        strap;
  logic [7:0]  delay;
  wire         busy;
  wire         taken_n;
  wire         sel_n;
  wire         rst_o_n;
  wire         lf_n;
  wire         latch_n;
  wire         gp_out;
  int          miscompares;
  int          cmp_count;
  int          cycles;
  integer      seed;
  logic [31:0] r;
  logic [31:0] v;
  logic [7:0]  q [$];

  assign bus = bus_oe ? bus_out : ext_byte;

  ppg_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .printer_data_bus_in(bus),
    .printer_data_bus_out(bus_out), .printer_data_bus_oe(bus_oe), .busy(busy),
    .taken_n(taken_n), .paper_out(paper), .printer_online(online), .fault_n(fault_n),
    .printer_port_strap(strap), .printer_select_n(sel_n), .restart_n(rst_o_n),
    .line_feed_auto_n(lf_n), .latch_pulse_n(latch_n), .gp_output(gp_out));
  ppg_printer_model u_prn (.hclk(hclk), .hresetn(hresetn), .latch_pulse_n(latch_n),
    .bus(bus), .delay(delay), .busy(busy), .taken_n(taken_n));

  always #10 hclk = ~hclk;

  task automatic end_sim;
    $display("Counts: %0d compared, %0d mismatched", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {22'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  // Reset lands just after a clock edge, so outputs must settle without another clock
  task automatic do_reset(input logic s);
    @(posedge hclk);
    strap   <= s;
    hresetn <= 1'b0;
    #1 chk("rst_pins", 32'h1f, {bus_oe, latch_n, sel_n, rst_o_n, lf_n, gp_out});
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
  endtask : do_reset

  initial begin
    hclk = 1'b0;
    hresetn = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    ext_byte = 8'h0;
    paper = 1'b0;
    online = 1'b0;
    fault_n = 1'b1;
    strap = 1'b1;
    delay = 8'd120;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    seed = 32'h0175;
    do_reset(1'b1);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      paper <= v[0];
      online <= v[1];
      fault_n <= v[2];
      ahb(1'b1, PPG_ADDR_LEVELS, {31'h0, v[3]});
      repeat (5) @(posedge hclk);
      ahb(1'b0, PPG_ADDR_LEVELS, 32'h0);
      chk("gpi2", v[2], r[PPG_LV_GPI2]);
      chk("gpi1", v[0], r[PPG_LV_GPI1]);
      chk("gpi0", v[1], r[PPG_LV_GPI0]);
      chk("gp_out", !v[3], gp_out);
    end
    ahb(1'b0, PPG_ADDR_STATUS, 32'h0);
    chk("mode", 32'h1, r[PPG_ST_MODE]);
    ahb(1'b1, PPG_ADDR_CONTROL, 32'h1);
    repeat (3) @(posedge hclk);
    chk("oe_mii", 32'h0, bus_oe);
    ahb(1'b1, 10'h40, 32'hff);
    ahb(1'b0, 10'h40, 32'h0);
    chk("unmapped", 32'h0, r);
    $display("test mii mode done");
    do_reset(1'b0);
    ahb(1'b0, PPG_ADDR_STATUS, 32'h0);
    chk("mode", 32'h0, r[PPG_ST_MODE]);
    ahb(1'b0, PPG_ADDR_LEVELS, 32'h0);
    chk("gpi1_prn", 32'h0, r[PPG_LV_GPI1]);
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      ext_byte <= v[7:0];
      paper <= v[8];
      online <= v[9];
      fault_n <= v[10];
      ahb(1'b1, PPG_ADDR_CONTROL, i);
      repeat (5) @(posedge hclk);
      chk("ctl_pins", {~i[3:1], i[0]}, {lf_n, rst_o_n, sel_n, bus_oe});
      ahb(1'b0, PPG_ADDR_STATUS, 32'h0);
      chk("status", {v[10:8], 2'b10}, r[4:0]);
      ahb(1'b0, PPG_ADDR_RDATA, 32'h0);
      chk("bus_in", i[0] ? 32'h0 : v[7:0], r[7:0]);
    end
    $display("test printer pins done");
    ahb(1'b1, PPG_ADDR_CONTROL, 32'h3);
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 32'hff : $random(seed);
      ahb(1'b1, PPG_ADDR_DATA, {24'h0, v[7:0]});
      if (i < 9) q.push_back(v[7:0]);
    end
    ahb(1'b0, PPG_ADDR_STATUS, 32'h0);
    chk("full", 32'h1, r[PPG_ST_FULL]);
    while (u_prn.n_cap < 9) begin
      @(posedge hclk);
      if (u_prn.n_cap == 4) delay <= 8'd0;
    end
    repeat (400) @(posedge hclk);
    chk("count", 32'd9, u_prn.n_cap);
    foreach (q[k]) chk("printed", q[k], u_prn.caps[k]);
    ahb(1'b0, PPG_ADDR_STATUS, 32'h0);
    chk("taken_seen", 32'h1, r[PPG_ST_READY]);
    chk("drained", 32'h0, r[PPG_ST_FULL]);
    ahb(1'b0, PPG_ADDR_STATUS, 32'h0);
    chk("taken_clr", 32'h0, r[PPG_ST_READY]);
    $display("test printing done");
    end_sim();
  end
endmodule : ppg_top_tb

bind ppg_top ppg_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy), .fault_n(fault_n),
  .printer_data_bus_out(printer_data_bus_out), .printer_data_bus_oe(printer_data_bus_oe),
  .printer_select_n(printer_select_n), .restart_n(restart_n),
  .line_feed_auto_n(line_feed_auto_n), .latch_pulse_n(latch_pulse_n),
  .gp_output(gp_output));
`default_nettype wire
